// *** logic/bdc_pkg.sv ***
package bdc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DUTY = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_STAT = 8'h02;
  localparam logic [7:0] ADDR_ID = 8'h03;
  localparam logic [7:0] ADDR_CURR = 8'h07;
  localparam logic [7:0] ADDR_CHAN = 8'h09;

  // Reset values
  localparam logic [7:0] RST_DUTY = 8'hff;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CURR = 8'hff;
  localparam logic [5:0] RST_CHAN = 6'h3f;

  // Field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_INTERP_BIT = 2;
  localparam int STAT_FAULT_BIT = 0;
  localparam int NUM_CHAN = 6;

  // Identification fields; maker code, revision and bus address values are arbitrary
  localparam logic PANEL_TYPE_BIT = 1'b1;
  localparam logic [3:0] MAKER_CODE = 4'h5;
  localparam logic [2:0] SILICON_REV = 3'h1;
  localparam logic [6:0] SLAVE_ADDR = 7'h2c;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int BL_ON_TIME_US = 4000;
  localparam int BL_ON_CYC = BL_ON_TIME_US * CLK_MHZ;
  localparam int BL_TIMER_BITS = 19;
  localparam logic [7:0] PWM_STEPS = 8'hff;
  localparam logic [3:0] PWM_PRESCALE = 4'hf;
  localparam int DUTY_WIN_BITS = 16;

  typedef struct packed {
    logic [1:0] rsv;
    logic two_down;
    logic one_down;
    logic bl_on;
    logic overcurrent;
    logic thermal;
    logic fault;
  } bdc_status_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } bdc_wr_type;

  typedef enum logic [3:0] {
    LK_IDLE = 4'h0,
    LK_ADDR = 4'h1,
    LK_ADDR_ACK = 4'h3,
    LK_CMD = 4'h2,
    LK_CMD_ACK = 4'h6,
    LK_WDATA = 4'h7,
    LK_WDATA_ACK = 4'h5,
    LK_DONE = 4'h4,
    LK_RDATA = 4'hc,
    LK_RACK = 4'hd
  } bdc_link_state_type;

endpackage : bdc_pkg

// *** logic/bdc_regs.sv ***
`timescale 1ns/10ps
module bdc_regs #(
  parameter int unsigned BL_ON_CYCLES = bdc_pkg::BL_ON_CYC
) (
  input wire logic mclk_in,                  // System clock
  input wire logic rst_n_in,                 // Async reset, active low
  input wire logic scl_in,                   // Bus clock pin
  input wire logic sda_in,                   // Bus data pin level
  output logic sda_out,                      // Bus data drive value
  output logic sda_oe_out,                   // Bus data drive enable
  input wire logic external_dim_in,          // External PWM dimming input
  input wire logic thermal_in,               // Thermal shutdown condition
  input wire logic overcurrent_in,           // Input overcurrent condition
  input wire logic [5:0] chan_fault_in,      // Per-channel fault conditions
  output logic led_pwm_out,                  // Dimming PWM to current sinks
  output logic [7:0] current_level_out,      // Drive current amplitude
  output logic backlight_on_out,             // Backlight on flag
  output logic [5:0] chan_enable_out         // Channels driven and healthy
);

  // Input synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic [8:0] in_meta;
  logic [8:0] in_sync;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      in_meta <= 9'h000;
      in_sync <= 9'h000;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      in_meta <= {external_dim_in, overcurrent_in, thermal_in, chan_fault_in};
      in_sync <= in_meta;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_sync[1] & ~scl_d;
  assign scl_fall = ~scl_sync[1] & scl_d;
  assign bus_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign bus_stop = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // Register storage
  logic [7:0] duty_level;
  logic [7:0] ctrl;
  logic [7:0] current_level;
  logic [5:0] channel_enable_mask;
  logic fault_sticky;
  logic bl_on_flag;
  logic [bdc_pkg::BL_TIMER_BITS-1:0] on_timer;
  logic [5:0] chan_dead;
  logic [7:0] meas_duty;
  logic [7:0] pwm_level;
  logic [7:0] next_eff;
  logic wr_stb;
  bdc_pkg::bdc_wr_type wr;
  bdc_pkg::bdc_status_type status;
  logic [7:0] chan_rd;
  logic [7:0] rd_data;

  logic wr_duty;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_curr;
  logic wr_chan;
  assign wr_duty = wr_stb && wr.addr == bdc_pkg::ADDR_DUTY;
  assign wr_ctrl = wr_stb && wr.addr == bdc_pkg::ADDR_CTRL;
  assign wr_stat = wr_stb && wr.addr == bdc_pkg::ADDR_STAT;
  assign wr_curr = wr_stb && wr.addr == bdc_pkg::ADDR_CURR;
  assign wr_chan = wr_stb && wr.addr == bdc_pkg::ADDR_CHAN;

  // Bus slave: Write Byte and Read Byte, pointer set by the command byte
  bdc_pkg::bdc_link_state_type link_state;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic [3:0] bit_cnt;
  logic rd_dir;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_state <= bdc_pkg::LK_IDLE;
      shreg <= 8'h00;
      ptr <= 8'h00;
      bit_cnt <= 4'h0;
      rd_dir <= 1'b0;
      sda_oe_out <= 1'b0;
      wr_stb <= 1'b0;
      wr <= '0;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        link_state <= bdc_pkg::LK_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (bus_stop) begin
        link_state <= bdc_pkg::LK_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        unique case (link_state)
          bdc_pkg::LK_IDLE, bdc_pkg::LK_DONE: begin
          end
          bdc_pkg::LK_ADDR, bdc_pkg::LK_CMD, bdc_pkg::LK_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              sda_oe_out <= 1'b1;
              if (link_state == bdc_pkg::LK_ADDR) begin
                if (shreg[7:1] == bdc_pkg::SLAVE_ADDR) begin
                  rd_dir <= shreg[0];
                  link_state <= bdc_pkg::LK_ADDR_ACK;
                end else begin
                  sda_oe_out <= 1'b0;
                  link_state <= bdc_pkg::LK_IDLE;
                end
              end else if (link_state == bdc_pkg::LK_CMD) begin
                ptr <= shreg;
                link_state <= bdc_pkg::LK_CMD_ACK;
              end else begin
                wr_stb <= 1'b1;
                wr <= '{addr: ptr, data: shreg};
                link_state <= bdc_pkg::LK_WDATA_ACK;
              end
            end
          end
          bdc_pkg::LK_ADDR_ACK: begin
            if (scl_fall) begin
              if (rd_dir) begin
                shreg <= rd_data;
                sda_oe_out <= ~rd_data[7];
                link_state <= bdc_pkg::LK_RDATA;
              end else begin
                sda_oe_out <= 1'b0;
                link_state <= bdc_pkg::LK_CMD;
              end
            end
          end
          bdc_pkg::LK_CMD_ACK, bdc_pkg::LK_WDATA_ACK: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              link_state <= (link_state == bdc_pkg::LK_CMD_ACK) ? bdc_pkg::LK_WDATA : bdc_pkg::LK_DONE;
            end
          end
          bdc_pkg::LK_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe_out <= 1'b0;
                link_state <= bdc_pkg::LK_RACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe_out <= ~shreg[6];
              end
            end
          end
          bdc_pkg::LK_RACK: begin
            if (scl_rise) begin
              link_state <= bdc_pkg::LK_DONE;
            end
          end
          default: begin
            link_state <= bdc_pkg::LK_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Host-written registers; reserved control bits are kept as written
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      duty_level <= bdc_pkg::RST_DUTY;
      ctrl <= bdc_pkg::RST_CTRL;
      current_level <= bdc_pkg::RST_CURR;
      channel_enable_mask <= bdc_pkg::RST_CHAN;
    end else begin
      if (wr_duty) begin
        duty_level <= wr.data;
      end
      if (wr_ctrl) begin
        ctrl <= wr.data;
      end
      if (wr_curr) begin
        current_level <= wr.data;
      end
      if (wr_chan) begin
        channel_enable_mask <= wr.data[5:0];
      end
    end
  end

  // Backlight sequencing: delayed on, immediate off
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_timer <= '0;
      bl_on_flag <= 1'b0;
    end else if (!ctrl[bdc_pkg::CTRL_ON_BIT] || (wr_ctrl && !wr.data[bdc_pkg::CTRL_ON_BIT])) begin
      on_timer <= '0;
      bl_on_flag <= 1'b0;
    end else if (!bl_on_flag) begin
      if (on_timer == bdc_pkg::BL_TIMER_BITS'(BL_ON_CYCLES - 1)) begin
        bl_on_flag <= 1'b1;
      end else begin
        on_timer <= on_timer + 1'b1;
      end
    end
  end

  // Faults count only once fully on, so an on-then-off command reports nothing
  logic [5:0] next_dead;
  logic any_cond;
  assign next_dead = (chan_dead | (in_sync[5:0] & channel_enable_mask & {6{bl_on_flag}}))
                     & channel_enable_mask & {6{bl_on_flag}};
  assign status.rsv = 2'b00;
  assign status.two_down = (chan_dead & (chan_dead - 6'h01)) != 6'h00;
  assign status.one_down = |chan_dead;
  assign status.bl_on = bl_on_flag;
  assign status.overcurrent = in_sync[7] & bl_on_flag;
  assign status.thermal = in_sync[6] & bl_on_flag;
  assign status.fault = fault_sticky;
  assign any_cond = status.two_down | status.one_down | status.overcurrent | status.thermal;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_dead <= 6'h00;
      fault_sticky <= 1'b0;
    end else begin
      chan_dead <= next_dead;
      if (any_cond) begin
        fault_sticky <= 1'b1;
      end else if (wr_stat && wr.data[bdc_pkg::STAT_FAULT_BIT]) begin
        fault_sticky <= 1'b0;
      end
    end
  end

  // Read mux
  assign chan_rd = {2'b00, channel_enable_mask & ~chan_dead & {6{bl_on_flag}}};
  always_comb begin
    unique case (ptr)
      bdc_pkg::ADDR_DUTY: rd_data = duty_level;
      bdc_pkg::ADDR_CTRL: rd_data = ctrl;
      bdc_pkg::ADDR_STAT: rd_data = status;
      bdc_pkg::ADDR_ID: rd_data = {bdc_pkg::PANEL_TYPE_BIT, bdc_pkg::MAKER_CODE, bdc_pkg::SILICON_REV};
      bdc_pkg::ADDR_CURR: rd_data = current_level;
      bdc_pkg::ADDR_CHAN: rd_data = chan_rd;
      default: rd_data = 8'h00;
    endcase
  end

  // External input duty, measured over a fixed window
  logic [bdc_pkg::DUTY_WIN_BITS-1:0] win_cnt;
  logic [bdc_pkg::DUTY_WIN_BITS-1:0] high_cnt;
  logic [bdc_pkg::DUTY_WIN_BITS:0] high_total;
  assign high_total = {1'b0, high_cnt} + {{bdc_pkg::DUTY_WIN_BITS{1'b0}}, in_sync[8]};

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      win_cnt <= '0;
      high_cnt <= '0;
      meas_duty <= 8'h00;
    end else begin
      win_cnt <= win_cnt + 1'b1;
      if (&win_cnt) begin
        high_cnt <= '0;
        meas_duty <= high_total[bdc_pkg::DUTY_WIN_BITS] ? 8'hff
                     : high_total[bdc_pkg::DUTY_WIN_BITS-1 -: 8];
      end else begin
        high_cnt <= high_total[bdc_pkg::DUTY_WIN_BITS-1:0];
      end
    end
  end

  // Dimming source selection
  logic [15:0] scaled;
  assign scaled = 16'(duty_level * meas_duty) + {8'h00, duty_level};
  always_comb begin
    if (ctrl[bdc_pkg::CTRL_SRC_BIT]) begin
      next_eff = meas_duty;
    end else if (ctrl[bdc_pkg::CTRL_INTERP_BIT]) begin
      next_eff = duty_level;
    end else begin
      next_eff = scaled[15:8];
    end
  end

  // PWM: 255 ticks per period, level latched at each period start
  logic [3:0] presc;
  logic pwm_tick;
  logic [7:0] pwm_cnt;
  assign pwm_tick = presc == bdc_pkg::PWM_PRESCALE;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc <= 4'h0;
      pwm_cnt <= 8'h00;
      pwm_level <= 8'h00;
    end else begin
      presc <= pwm_tick ? 4'h0 : presc + 4'h1;
      if (pwm_tick) begin
        if (pwm_cnt == bdc_pkg::PWM_STEPS - 8'h01) begin
          pwm_cnt <= 8'h00;
          pwm_level <= next_eff;
        end else begin
          pwm_cnt <= pwm_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_pwm_out <= 1'b0;
      current_level_out <= bdc_pkg::RST_CURR;
      backlight_on_out <= 1'b0;
      chan_enable_out <= 6'h00;
    end else begin
      led_pwm_out <= bl_on_flag && pwm_cnt < pwm_level;
      current_level_out <= current_level;
      backlight_on_out <= bl_on_flag;
      chan_enable_out <= chan_rd[5:0];
    end
  end

  property p_off_now;
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_ctrl && !wr.data[bdc_pkg::CTRL_ON_BIT] |=> !bl_on_flag && chan_rd == 8'h00;
  endproperty
  a_off_now: assert property (p_off_now) else $error("backlight not off after off write");

  property p_off_dark;
    @(posedge mclk_in) disable iff (!rst_n_in)
    !ctrl[bdc_pkg::CTRL_ON_BIT] |=> !led_pwm_out && !backlight_on_out;
  endproperty
  a_off_dark: assert property (p_off_dark) else $error("output active while off");

  property p_on_time;
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(bl_on_flag) |-> ctrl[bdc_pkg::CTRL_ON_BIT] && $past(on_timer) == bdc_pkg::BL_TIMER_BITS'(BL_ON_CYCLES - 1);
  endproperty
  a_on_time: assert property (p_on_time) else $error("on delay wrong");

  property p_fault_sticky;
    @(posedge mclk_in) disable iff (!rst_n_in)
    fault_sticky && !wr_stat |=> fault_sticky;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault lost without clear");

  property p_fault_set;
    @(posedge mclk_in) disable iff (!rst_n_in)
    any_cond |=> fault_sticky;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not set");

  property p_two_one;
    @(posedge mclk_in) disable iff (!rst_n_in)
    status.two_down |-> status.one_down && status.rsv == 2'b00;
  endproperty
  a_two_one: assert property (p_two_one) else $error("channel down flags inconsistent");

  property p_duty_store;
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_duty |=> duty_level == $past(wr.data) ##1 duty_level == $past(wr.data, 2);
  endproperty
  a_duty_store: assert property (p_duty_store) else $error("duty level not stored");

  property p_scaled;
    @(posedge mclk_in) disable iff (!rst_n_in)
    !ctrl[bdc_pkg::CTRL_SRC_BIT] && !ctrl[bdc_pkg::CTRL_INTERP_BIT] |-> next_eff <= duty_level && next_eff <= meas_duty;
  endproperty
  a_scaled: assert property (p_scaled) else $error("scaled level out of range");

  property p_zero_dark;
    @(posedge mclk_in) disable iff (!rst_n_in)
    pwm_level == 8'h00 |=> !led_pwm_out;
  endproperty
  a_zero_dark: assert property (p_zero_dark) else $error("zero level drives output");

  property p_full;
    @(posedge mclk_in) disable iff (!rst_n_in)
    bl_on_flag && pwm_level == 8'hff |=> led_pwm_out;
  endproperty
  a_full: assert property (p_full) else $error("full level not continuous");

  property p_wr_ack;
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_stb |-> sda_oe_out && link_state == bdc_pkg::LK_WDATA_ACK;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write without acknowledge");

endmodule : bdc_regs

// *** test/bdc_host_model.sv ***
`timescale 1ns/10ps
module bdc_host_model (
  input wire logic mclk_in, // Pacing clock
  input wire logic sda_in,  // Resolved data wire
  output logic scl_out,     // Bus clock drive
  output logic sda_low_out  // High pulls data low
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // One quarter of the 80 ns bus clock
  task automatic qtr;
    repeat (2) @(negedge mclk_in);
  endtask : qtr
  task automatic put_bit(input logic b);
    qtr();
    sda_low_out = ~b;
    qtr();
    scl_out = 1'b1;
    qtr();
    qtr();
    scl_out = 1'b0;
  endtask : put_bit
  // Released line floats to the pull-up level
  task automatic get_bit(output logic b);
    qtr();
    sda_low_out = 1'b0;
    qtr();
    scl_out = 1'b1;
    qtr();
    b = sda_in;
    qtr();
    scl_out = 1'b0;
  endtask : get_bit
  task automatic start_cond;
    qtr();
    sda_low_out = 1'b0;
    qtr();
    scl_out = 1'b1;
    qtr();
    sda_low_out = 1'b1;
    qtr();
    scl_out = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    qtr();
    sda_low_out = 1'b1;
    qtr();
    scl_out = 1'b1;
    qtr();
    sda_low_out = 1'b0;
    qtr();
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, inout logic nack);
    logic n;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(n);
    nack = nack | n;
  endtask : send_byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] cmd, input logic [7:0] data,
                           output logic nack);
    nack = 1'b0;
    start_cond();
    send_byte({dev, 1'b0}, nack);
    send_byte(cmd, nack);
    send_byte(data, nack);
    stop_cond();
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] cmd, output logic [7:0] data,
                          output logic nack);
    nack = 1'b0;
    start_cond();
    send_byte({dev, 1'b0}, nack);
    send_byte(cmd, nack);
    start_cond();
    send_byte({dev, 1'b1}, nack);
    for (int i = 7; i >= 0; i--) get_bit(data[i]);
    put_bit(1'b1);
    stop_cond();
  endtask : read_reg
endmodule : bdc_host_model

// *** test/tb_bdc_regs.sv ***
`timescale 1ns/10ps
module tb_bdc_regs;
  logic mclk_in, rst_n_in, scl, host_low, sda_out, sda_oe, ext_dim, thermal, overcurrent;
  logic led_pwm, bl_on, nack;
  logic [5:0] chan_fault, chan_en;
  logic [7:0] curr_level, d;
  logic [15:0] n;
  logic [7:0] lv [3] = '{8'h80, 8'h00, 8'hff};
  wire sda = ~((sda_oe & ~sda_out) | host_low);
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  bdc_host_model u_host (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  bdc_regs #(.BL_ON_CYCLES(20)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .external_dim_in(ext_dim), .thermal_in(thermal),
    .overcurrent_in(overcurrent), .chan_fault_in(chan_fault), .led_pwm_out(led_pwm),
    .current_level_out(curr_level), .backlight_on_out(bl_on), .chan_enable_out(chan_en));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_host.write_reg(bdc_pkg::SLAVE_ADDR, a, v, nack);
    check("write ack", {15'h0, nack}, 16'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_host.read_reg(bdc_pkg::SLAVE_ADDR, a, d, nack);
    check("read ack", {15'h0, nack}, 16'h0);
    check("read data", {8'h0, d}, {8'h0, exp});
  endtask : rd
  task automatic wait_cyc(input int k);
    repeat (k) @(negedge mclk_in);
  endtask : wait_cyc
  // Lets a new level reach the period latch, then counts high cycles over two whole periods
  task automatic pwm_count(input logic [7:0] lvl);
    wait_cyc(4200);
    n = 16'h0;
    repeat (8160) begin
      @(negedge mclk_in);
      n = n + {15'h0, led_pwm};
    end
    check("pwm high count", n, {3'h0, lvl, 5'h0});
  endtask : pwm_count
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    ext_dim = 1'b0;
    thermal = 1'b0;
    overcurrent = 1'b0;
    chan_fault = 6'h00;
    wait_cyc(5);
    rst_n_in = 1'b1;
    wait_cyc(4);
    check("current out", {8'h0, curr_level}, 16'h00ff);
    rd(bdc_pkg::ADDR_DUTY, 8'hff);
    rd(bdc_pkg::ADDR_CTRL, 8'h00);
    rd(bdc_pkg::ADDR_CURR, 8'hff);
    rd(bdc_pkg::ADDR_STAT, 8'h00);
    rd(bdc_pkg::ADDR_CHAN, 8'h00);
    rd(bdc_pkg::ADDR_ID, {bdc_pkg::PANEL_TYPE_BIT, bdc_pkg::MAKER_CODE, bdc_pkg::SILICON_REV});
    wr(bdc_pkg::ADDR_ID, 8'h00);
    rd(bdc_pkg::ADDR_ID, {bdc_pkg::PANEL_TYPE_BIT, bdc_pkg::MAKER_CODE, bdc_pkg::SILICON_REV});
    wr(bdc_pkg::ADDR_DUTY, 8'h5a);
    wr(bdc_pkg::ADDR_CURR, 8'h3c);
    rd(bdc_pkg::ADDR_DUTY, 8'h5a);
    rd(bdc_pkg::ADDR_CURR, 8'h3c);
    check("current out", {8'h0, curr_level}, 16'h003c);
    wr(bdc_pkg::ADDR_STAT, 8'hfe);
    rd(bdc_pkg::ADDR_STAT, 8'h00);
    rd(8'h05, 8'h00);
    u_host.write_reg(bdc_pkg::SLAVE_ADDR ^ 7'h01, bdc_pkg::ADDR_DUTY, 8'h11, nack);
    check("foreign address nack", {15'h0, nack}, 16'h0001);
    rd(bdc_pkg::ADDR_DUTY, 8'h5a);
    wr(bdc_pkg::ADDR_CTRL, 8'hf8);
    rd(bdc_pkg::ADDR_CTRL, 8'hf8);
    wait_cyc(40);
    check("backlight off", {15'h0, bl_on}, 16'h0);
    // Register-controlled dimming, backlight on
    wr(bdc_pkg::ADDR_CTRL, 8'h05);
    wait_cyc(30);
    check("backlight on", {15'h0, bl_on}, 16'h1);
    rd(bdc_pkg::ADDR_STAT, 8'h08);
    rd(bdc_pkg::ADDR_CHAN, 8'h3f);
    check("channels out", {10'h0, chan_en}, 16'h003f);
    // Two whole PWM periods of 255 ticks of 16 cycles
    foreach (lv[i]) begin
      wr(bdc_pkg::ADDR_DUTY, lv[i]);
      pwm_count(lv[i]);
    end
    thermal = 1'b1;
    overcurrent = 1'b1;
    wait_cyc(10);
    rd(bdc_pkg::ADDR_STAT, 8'h0f);
    thermal = 1'b0;
    overcurrent = 1'b0;
    wait_cyc(10);
    rd(bdc_pkg::ADDR_STAT, 8'h09);
    wr(bdc_pkg::ADDR_STAT, 8'hff);
    rd(bdc_pkg::ADDR_STAT, 8'h08);
    chan_fault = 6'h03;
    wait_cyc(10);
    chan_fault = 6'h00;
    wait_cyc(10);
    rd(bdc_pkg::ADDR_STAT, 8'h39);
    rd(bdc_pkg::ADDR_CHAN, 8'h3c);
    check("channels out", {10'h0, chan_en}, 16'h003c);
    // Disabling and re-enabling the faulted channels retries them
    wr(bdc_pkg::ADDR_CHAN, 8'h3c);
    wr(bdc_pkg::ADDR_CHAN, 8'h3f);
    rd(bdc_pkg::ADDR_CHAN, 8'h3f);
    // Scaled mode keeps the written duty level; an idle external input scales it to nothing
    wr(bdc_pkg::ADDR_CTRL, 8'h01);
    rd(bdc_pkg::ADDR_DUTY, 8'hff);
    pwm_count(8'h00);
    // External source wins over the interpretation bit
    wr(bdc_pkg::ADDR_CTRL, 8'h07);
    rd(bdc_pkg::ADDR_CTRL, 8'h07);
    pwm_count(8'h00);
    wr(bdc_pkg::ADDR_CTRL, 8'h04);
    wait_cyc(2);
    check("backlight off", {15'h0, bl_on}, 16'h0);
    rd(bdc_pkg::ADDR_CHAN, 8'h00);
    u_host.read_reg(bdc_pkg::SLAVE_ADDR, bdc_pkg::ADDR_STAT, d, nack);
    check("status on bit", {15'h0, d[3]}, 16'h0);
    end_of_test();
  end
endmodule : tb_bdc_regs
